//--- logic/icms_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// counter sequencer for modes 1 to 5; a zero count stands for 65536
// count_clk and gate are sampled on core_clk; a pulse is acted on at the
// first edge that sees the count clock low again, so the count clock must
// stand high and low for at least one core cycle each
module icms_sequencer (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic count_clk,
    input wire logic gate,
    input wire icms_pkg::icms_mode_type mode,
    input wire logic mode_wr,
    input wire logic [icms_pkg::ICMS_COUNT_W-1:0] count_holding_register,
    input wire logic count_wr,
    output logic timer_out,
    output logic null_count,
    output logic [icms_pkg::ICMS_COUNT_W-1:0] count_element,
    output logic terminal_count
);
    localparam logic [icms_pkg::ICMS_COUNT_W-1:0] ONE = icms_pkg::ICMS_CNT_ONE;
    localparam logic [icms_pkg::ICMS_COUNT_W-1:0] TWO = icms_pkg::ICMS_CNT_TWO;
    localparam logic [icms_pkg::ICMS_COUNT_W-1:0] ZERO =
        icms_pkg::ICMS_CNT_ZERO;

    // pin history and pulse tracking
    logic clk_d_r;
    logic gate_d_r;
    logic clk_hi_r;

    // pending events and sequence state
    logic trig_r;
    logic load_pend_r;
    logic armed_r;
    logic running_r;
    logic odd_wait_r;

    // counting element
    logic [icms_pkg::ICMS_COUNT_W-1:0] ce_r;

    // decoded events
    logic pulse;
    logic gate_rise;
    logic gate_fall;
    logic use_trig;
    logic odd_hi_end;

    logic do_load;
    logic [icms_pkg::ICMS_COUNT_W-1:0] load_val;

    // next-state values
    logic [icms_pkg::ICMS_COUNT_W-1:0] ce_nxt;
    logic out_nxt;
    logic run_nxt;
    logic odd_nxt;
    logic tc_nxt;

    // a pulse completes on the falling edge after a seen rise
    assign pulse = clk_d_r & ~count_clk & clk_hi_r;
    assign gate_rise = gate & ~gate_d_r;
    assign gate_fall = ~gate & gate_d_r;

    // one-cycle history of the two pin inputs for edge detection
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clk_d_r <= 1'b0;
            gate_d_r <= 1'b0;
        end else begin
            clk_d_r <= count_clk;
            gate_d_r <= gate;
        end
    end

    // the rise of the count clock opens a pulse; triggers land at its fall
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clk_hi_r <= 1'b0;
        end else if (count_clk & ~clk_d_r) begin
            clk_hi_r <= 1'b1;
        end else if (pulse) begin
            clk_hi_r <= 1'b0;
        end
    end

    // trigger held until a pulse consumes it; a new edge wins over the clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trig_r <= 1'b0;
        end else if (gate_rise) begin
            trig_r <= 1'b1;
        end else if (pulse || mode_wr) begin
            trig_r <= 1'b0;
        end
    end

    // count written and not yet copied into the counting element
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            load_pend_r <= 1'b0;
        end else if (count_wr || mode_wr) begin
            load_pend_r <= 1'b1;
        end else if (pulse && do_load) begin
            load_pend_r <= 1'b0;
        end
    end

    // one-shot and hard strobe need a written count before a trigger counts
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            armed_r <= 1'b0;
        end else if (mode_wr) begin
            armed_r <= 1'b0;
        end else if (count_wr) begin
            armed_r <= 1'b1;
        end
    end

    assign use_trig = trig_r & armed_r;

    // odd square wave counts start one lower so the step of two lands on zero
    always_comb begin
        load_val = count_holding_register;
        if (mode == icms_pkg::ICMS_MODE_SQUARE &&
            count_holding_register[0]) begin
            load_val = count_holding_register - ONE;
        end
    end

    // high half of an odd count expires: one more high pulse before the low
    assign odd_hi_end = count_holding_register[0] & timer_out &
        (ce_r == TWO);

    // when the holding register is copied into the counting element
    always_comb begin
        do_load = 1'b0;
        unique case (mode)
            icms_pkg::ICMS_MODE_ONE_SHOT: begin
                do_load = use_trig;
            end
            icms_pkg::ICMS_MODE_RATE: begin
                do_load = (load_pend_r && !running_r) || (trig_r && gate)
                    || (gate && running_r && ce_r == ONE);
            end
            icms_pkg::ICMS_MODE_SQUARE: begin
                // odd counts hold the high half one pulse longer
                do_load = (load_pend_r && !running_r) || (trig_r && gate)
                    || (gate && running_r && !odd_wait_r && !odd_hi_end
                        && ce_r == TWO);
            end
            icms_pkg::ICMS_MODE_SOFT_STROBE: begin
                do_load = load_pend_r && count_wr == 1'b0;
            end
            icms_pkg::ICMS_MODE_HARD_STROBE: begin
                do_load = use_trig;
            end
            default: begin
                do_load = 1'b0;
            end
        endcase
    end

    // next counting element and output, applied only on a pulse
    always_comb begin
        ce_nxt = ce_r;
        out_nxt = timer_out;
        run_nxt = running_r;
        odd_nxt = odd_wait_r;
        tc_nxt = 1'b0;
        unique case (mode)
            icms_pkg::ICMS_MODE_ONE_SHOT: begin
                if (do_load) begin
                    ce_nxt = count_holding_register;
                    out_nxt = 1'b0;
                    run_nxt = 1'b1;
                end else if (running_r) begin
                    ce_nxt = ce_r - ONE;
                    if (ce_r == ONE) begin
                        out_nxt = 1'b1;
                        run_nxt = 1'b0;
                        tc_nxt = 1'b1;
                    end
                end
            end

            icms_pkg::ICMS_MODE_RATE: begin
                // gate low freezes the count; the output stays high meanwhile
                out_nxt = 1'b1;
                if (do_load) begin
                    ce_nxt = count_holding_register;
                    run_nxt = 1'b1;
                    tc_nxt = running_r && ce_r == ONE;
                end else if (gate && running_r) begin
                    ce_nxt = ce_r - ONE;
                    // output low for the pulse that holds the count at 1
                    out_nxt = !(ce_r == TWO);
                end
            end

            icms_pkg::ICMS_MODE_SQUARE: begin
                if (do_load) begin
                    ce_nxt = load_val;
                    odd_nxt = 1'b0;
                    // a trigger or first load restarts the high half
                    if (running_r && !trig_r) begin
                        out_nxt = ~timer_out;
                    end else begin
                        out_nxt = 1'b1;
                    end
                    run_nxt = 1'b1;
                    tc_nxt = running_r;
                end else if (odd_wait_r) begin
                    // odd count: extra high pulse before the low half
                    ce_nxt = load_val;
                    out_nxt = 1'b0;
                    odd_nxt = 1'b0;
                end else if (gate && running_r) begin
                    ce_nxt = ce_r - TWO;
                    if (odd_hi_end) begin
                        odd_nxt = 1'b1;
                    end
                end
            end

            icms_pkg::ICMS_MODE_SOFT_STROBE, icms_pkg::ICMS_MODE_HARD_STROBE:
            begin
                // hard strobe counts regardless of the gate level
                out_nxt = 1'b1;
                if (do_load) begin
                    ce_nxt = count_holding_register;
                    run_nxt = 1'b1;
                end else if (running_r && (gate ||
                    mode == icms_pkg::ICMS_MODE_HARD_STROBE)) begin
                    ce_nxt = ce_r - ONE;
                    if (ce_r == ONE) begin
                        out_nxt = 1'b0;
                        run_nxt = 1'b0;
                        tc_nxt = 1'b1;
                    end
                end
            end

            default: begin
                ce_nxt = ce_r;
            end
        endcase
    end

    // gate low in rate and square modes sets the output high at once
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            timer_out <= 1'b1;
        end else if (mode_wr) begin
            // a control word parks the output high until counting restarts
            timer_out <= 1'b1;
        end else if (gate_fall && (mode == icms_pkg::ICMS_MODE_RATE ||
            mode == icms_pkg::ICMS_MODE_SQUARE)) begin
            timer_out <= 1'b1;
        end else if (pulse) begin
            timer_out <= out_nxt;
        end
    end

    // the counting element and its run state move only on a completed pulse;
    // a control word stops the sequence but keeps the count for read-back
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ce_r <= ZERO;
            running_r <= 1'b0;
            odd_wait_r <= 1'b0;
            terminal_count <= 1'b0;
        end else if (mode_wr) begin
            running_r <= 1'b0;
            odd_wait_r <= 1'b0;
            terminal_count <= 1'b0;
        end else if (pulse) begin
            ce_r <= ce_nxt;
            running_r <= run_nxt;
            odd_wait_r <= odd_nxt;
            terminal_count <= tc_nxt;
        end else begin
            terminal_count <= 1'b0;
        end
    end

    // the visible count trails the counting element by one core cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_element <= ZERO;
        end else begin
            count_element <= ce_r;
        end
    end

    // null count: written but not yet copied into the counting element
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            null_count <= 1'b0;
        end else if (count_wr || mode_wr) begin
            null_count <= 1'b1;
        end else if (pulse && do_load) begin
            null_count <= 1'b0;
        end
    end
endmodule // icms_sequencer
`default_nettype wire

//--- inc/icms_pkg.sv
// Behaviour
// - one-shot: new count waits for a retrigger; a retrigger loads it and restarts.
// - rate generator: output high, low one pulse at count 1, reload, period N.
// - rate generator: gate high counts; gate low forces output high at once.
// - rate generator: trigger reloads on next pulse; output low N pulses later.
// - rate generator: count written loads on next pulse; low N pulses later.
// - rate generator: new count loads on trigger or at end of period.
// - square wave: high first half, low remainder, period N, repeats.
// - square wave: gate low stops counting; output high immediately.
// - square wave: trigger or count write loads on the next pulse.
// - square wave: new count loads on trigger or at end of half-cycle.
// - square wave even: load N, step by two, toggle and reload at expiry.
// - square wave odd: load N-1, high (N+1)/2, low (N-1)/2 pulses.
// - soft strobe: write starts; load pulse no decrement; strobe N+1 later.
// - soft strobe: gate enables counting, never touches output.
// - soft strobe: new count loads next pulse; first byte of two has no effect.
// - hard strobe: gate rise starts; load without decrement; strobe N+1 later.
// - hard strobe retriggerable; gate never touches the output directly.
// - hard strobe: new count loads only on trigger before expiry.
// - a count pulse is a rise then fall of the count clock input.
// - a trigger is a rising edge of the gate input.
// - loading copies the count holding register into the counting element, less one for an odd square wave count.
// - one-shot and hard strobe sample triggers on count clock falls.
package icms_pkg;
    typedef enum logic [2:0] {
        ICMS_MODE_ONE_SHOT = 3'h1,
        ICMS_MODE_RATE = 3'h2,
        ICMS_MODE_SQUARE = 3'h3,
        ICMS_MODE_SOFT_STROBE = 3'h4,
        ICMS_MODE_HARD_STROBE = 3'h5
    } icms_mode_type;
    localparam int ICMS_COUNT_W = 16;
    localparam logic [ICMS_COUNT_W-1:0] ICMS_CNT_ONE = 16'h0001;
    localparam logic [ICMS_COUNT_W-1:0] ICMS_CNT_TWO = 16'h0002;
    localparam logic [ICMS_COUNT_W-1:0] ICMS_CNT_ZERO = 16'h0000;
endpackage

//--- test/icms_sequencer_properties.sv
`timescale 1ns/100ps
`default_nettype none
module icms_sequencer_properties (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic count_clk,
    input wire logic gate,
    input wire icms_pkg::icms_mode_type mode,
    input wire logic mode_wr,
    input wire logic [icms_pkg::ICMS_COUNT_W-1:0] count_holding_register,
    input wire logic count_wr,
    input wire logic timer_out,
    input wire logic null_count,
    input wire logic [icms_pkg::ICMS_COUNT_W-1:0] count_element,
    input wire logic terminal_count
);
    // cycles the count clock has stood low; the count and the strobe output may not move long after
    logic [3:0] low_r;
    logic [2:0] mw_r;
    wire logic sm = mode > icms_pkg::ICMS_MODE_SQUARE;
    wire logic wm = mode == icms_pkg::ICMS_MODE_RATE ||
        mode == icms_pkg::ICMS_MODE_SQUARE;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) low_r <= 4'h0;
        else low_r <= count_clk ? 4'h0 : low_r + {3'h0, low_r != 4'hf};
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) mw_r <= 3'h0;
        else mw_r <= {mw_r[1:0], mode_wr};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_low;
        wm && !timer_out;
    endsequence
    sequence s_drop;
        s_low ##1 ($fell(gate) && wm);
    endsequence
    property p_tc_one; terminal_count |=> !terminal_count; endproperty
    property p_wr_null; count_wr |=> null_count; endproperty
    property p_mode_out; mode_wr |=> ##[0:1] timer_out; endproperty
    property p_gate_drop; s_drop |-> ##[0:3] timer_out; endproperty
    property p_strobe; $fell(timer_out) && sm |-> !timer_out [*3];
    endproperty
    property p_ce_pulse; $changed(count_element) |-> low_r < 4'h7;
    endproperty
    property p_out_pulse;
        $changed(timer_out) && sm && mw_r == 3'h0 |-> low_r < 4'h7;
    endproperty
    property p_rate_step;
        $changed(count_element) && mode == icms_pkg::ICMS_MODE_RATE &&
        count_element < $past(count_element) && mw_r == 3'h0 &&
        count_element != count_holding_register
        |-> count_element == $past(count_element) - 16'h0001;
    endproperty
    a_tc_one: assert property (p_tc_one)
        else $error("terminal count too long");
    a_wr_null: assert property (p_wr_null)
        else $error("null count not set");
    a_mode_out: assert property (p_mode_out)
        else $error("output not high after mode write");
    a_gate_drop: assert property (p_gate_drop)
        else $error("output not forced high");
    a_strobe: assert property (p_strobe)
        else $error("strobe too short");
    a_ce_pulse: assert property (p_ce_pulse)
        else $error("count moved without a pulse");
    a_out_pulse: assert property (p_out_pulse)
        else $error("strobe output moved without a pulse");
    a_rate_step: assert property (p_rate_step)
        else $error("rate count step wrong");
endmodule // icms_sequencer_properties
bind icms_sequencer icms_sequencer_properties chk_u (.*);
`default_nettype wire

//--- test/icms_source.sv
`timescale 1ns/100ps
`default_nettype none
module icms_source (
    input wire logic core_clk,
    output logic count_clk,
    output logic gate
);
    initial begin
        count_clk = 1'b0;
        gate = 1'b0;
    end
    // clock stands low between pulses; ends off the edge to avoid races
    task automatic pulse();
        @(posedge core_clk);
        #1 count_clk = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 count_clk = 1'b0;
        repeat (4) @(posedge core_clk);
        #2;
    endtask
    // gate moves only while the clock idles, never next to terminal count
    task automatic set_gate(input logic v);
        @(posedge core_clk);
        #1 gate = v;
        repeat (3) @(posedge core_clk);
        #2;
    endtask
endmodule // icms_source
`default_nettype wire

//--- test/icms_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module icms_sequencer_tb;
    typedef struct {
        icms_pkg::icms_mode_type m;
        int n;
    } icms_row_type;
    localparam icms_pkg::icms_mode_type m_one = icms_pkg::ICMS_MODE_ONE_SHOT,
        m_rate = icms_pkg::ICMS_MODE_RATE,
        m_sq = icms_pkg::ICMS_MODE_SQUARE,
        m_soft = icms_pkg::ICMS_MODE_SOFT_STROBE,
        m_hard = icms_pkg::ICMS_MODE_HARD_STROBE;
    // two is the shortest legal rate count; one is never sent
    icms_row_type rows [8] = '{'{m_rate, 3}, '{m_rate, 2}, '{m_sq, 4},
        '{m_sq, 5}, '{m_sq, 3}, '{m_soft, 3}, '{m_hard, 2}, '{m_one, 3}};
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    icms_pkg::icms_mode_type mode = m_rate;
    logic mode_wr = 1'b0;
    logic [15:0] chr = 16'h0000;
    logic count_wr = 1'b0;
    wire logic count_clk;
    wire logic gate;
    logic timer_out;
    logic null_count;
    logic terminal_count;
    logic [15:0] ce;
    logic [15:0] en;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 core_clk = ~core_clk;
    icms_source src_u (.core_clk(core_clk), .count_clk(count_clk),
        .gate(gate));
    icms_sequencer dut_u (.core_clk(core_clk), .rstn(rstn),
        .count_clk(count_clk), .gate(gate), .mode(mode), .mode_wr(mode_wr),
        .count_holding_register(chr), .count_wr(count_wr),
        .timer_out(timer_out), .null_count(null_count),
        .count_element(ce), .terminal_count(terminal_count));
    task automatic results();
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic eo(icms_pkg::icms_mode_type m, int n, int k);
        case (m)
            m_one: eo = k > n;
            m_rate: eo = (k % n) != 0;
            m_sq: eo = ((k - 1) % n) < ((n + 1) / 2);
            default: eo = k != n + 1;
        endcase
    endfunction
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic load(input icms_pkg::icms_mode_type m,
        input logic [15:0] n, input logic cw);
        step();
        mode = m;
        mode_wr = cw;
        step();
        mode_wr = 1'b0;
        chr = n;
        count_wr = 1'b1;
        step();
        count_wr = 1'b0;
    endtask
    task automatic trig();
        src_u.set_gate(1'b0);
        src_u.set_gate(1'b1);
    endtask
    task automatic run(input icms_pkg::icms_mode_type m, input int n,
        input int k0, input int k1);
        for (int k = k0; k <= k1; k++) begin
            src_u.pulse();
            chk("timer_out", {15'h0000, timer_out},
                {15'h0000, eo(m, n, k)});
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        #1 rstn = 1'b1;
        foreach (rows[i]) begin
            en = 16'(rows[i].n);
            load(rows[i].m, en, 1'b1);
            chk("null_count", {15'h0000, null_count}, 16'h0001);
            trig();
            run(rows[i].m, rows[i].n, 1, 1);
            chk("count_element", ce,
                (rows[i].m == m_sq) ? en & 16'hfffe : en);
            chk("null_count", {15'h0000, null_count}, 16'h0000);
            run(rows[i].m, rows[i].n, 2, 2 * rows[i].n + 2);
        end
        load(m_rate, 16'h0002, 1'b1);
        trig();
        run(m_rate, 2, 1, 2);
        step();
        rstn = 1'b0;
        step();
        chk("reset_ce", ce, 16'h0000);
        chk("reset_out", {13'h0000, timer_out, null_count,
            terminal_count}, 16'h0004);
        rstn = 1'b1;
        load(m_rate, 16'h0003, 1'b1);
        trig();
        run(m_rate, 3, 1, 3);
        src_u.set_gate(1'b0);
        chk("timer_out", {15'h0000, timer_out}, 16'h0001);
        src_u.pulse();
        chk("count_element", ce, 16'h0001);
        src_u.set_gate(1'b1);
        run(m_rate, 3, 1, 4);
        load(m_sq, 16'h0004, 1'b1);
        trig();
        run(m_sq, 4, 1, 3);
        src_u.set_gate(1'b0);
        chk("timer_out", {15'h0000, timer_out}, 16'h0001);
        load(m_soft, 16'h0005, 1'b1);
        trig();
        run(m_soft, 5, 1, 2);
        load(m_soft, 16'h0002, 1'b0);
        run(m_soft, 2, 1, 4);
        load(m_hard, 16'h0003, 1'b1);
        trig();
        run(m_hard, 3, 1, 2);
        load(m_hard, 16'h0002, 1'b0);
        run(m_hard, 3, 3, 3);
        // two rises before one pulse must act as a single trigger
        trig();
        trig();
        run(m_hard, 2, 1, 4);
        load(m_rate, 16'h0004, 1'b1);
        trig();
        run(m_rate, 4, 1, 1);
        load(m_rate, 16'h0003, 1'b0);
        run(m_rate, 4, 2, 4);
        run(m_rate, 3, 1, 6);
        load(m_one, 16'h0004, 1'b1);
        trig();
        run(m_one, 4, 1, 1);
        load(m_one, 16'h0002, 1'b0);
        run(m_one, 4, 2, 5);
        trig();
        run(m_one, 2, 1, 3);
        results();
    end
endmodule // icms_sequencer_tb
`default_nettype wire
